// *** hdl/ria_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ria_top
  import ria_pkg::*;
#(
  parameter int LF_DIV = LF_PER_STEP,
  parameter int LEAD_MAX = LEAD_MAX_STEPS,
  parameter int INTV_MIN = INTV_MIN_STEPS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Slow timebase pin
  input wire logic lf_clk_pin,
  // Radio logic, same clock
  input wire logic radio_active,
  input wire logic evt_anchor,
  // Indicator pin
  output logic act_ind
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ria_ctrl_t ctrl_ff;
  ria_stat_t stat;
  logic [15:0] intv_ff;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [31:0] evcnt_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_rdata;
  logic ack_ff;
  logic ind_ff;
  logic pin_ff;
  logic win_ff;
  logic lf_rise;
  logic step;
  logic req;
  logic wr_do;
  logic suppressed;
  logic lead_win;
  logic nxt_ind;
  logic [6:0] lead_eff;
  logic [6:0] wr_lead;

  ////////////////////////////////////////////////////////////////////////////
  // Slow timebase: pin synchroniser and step divider
  ria_sync u_sync
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(lf_clk_pin),
    .dout(),
    .rise(lf_rise)
  );

  ria_step_gen #(.DIV(LF_DIV)) u_step
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .lf_rise(lf_rise),
    .step(step)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then answer
  assign req = read | write;
  assign waitrequest = req & ~ack_ff;
  assign wr_do = write & ack_ff;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lead field from a write, clamped to the longest lead
  always_comb
  begin
    if (writedata[CTRL_LEAD_LSB +: CTRL_LEAD_W] > 7'(LEAD_MAX))
    begin
      wr_lead = 7'(LEAD_MAX);
    end
    else
    begin
      wr_lead = writedata[CTRL_LEAD_LSB +: CTRL_LEAD_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, stored setup loaded at reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_ff.en <= RST_EN;
      ctrl_ff.pol <= RST_POL;
      ctrl_ff.lead <= RST_LEAD;
    end
    else if (wr_do && address == OFS_CTRL)
    begin
      if (byteenable[0])
      begin
        ctrl_ff.en <= writedata[CTRL_EN_BIT];
        ctrl_ff.pol <= writedata[CTRL_POL_BIT];
      end
      if (byteenable[1])
      begin
        ctrl_ff.lead <= wr_lead;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event interval in steps, rewritten on every interval update
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      intv_ff <= RST_INTV;
    end
    else if (wr_do && address == OFS_INTV)
    begin
      if (byteenable[0])
      begin
        intv_ff[7:0] <= writedata[7:0];
      end
      if (byteenable[1])
      begin
        intv_ff[15:8] <= writedata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Suppression follows the live interval, so it lifts by itself
  assign suppressed = intv_ff < 16'(INTV_MIN);

  ////////////////////////////////////////////////////////////////////////////
  // Steps left to the next scheduled radio start
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (evt_anchor)
    begin
      nxt_cnt = intv_ff; // Resync on the real start
    end
    else if (step)
    begin
      if (cnt_ff == 16'h0000)
      begin
        nxt_cnt = intv_ff - 16'h0001;
      end
      else
      begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_ff <= 16'h0000;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lead window: open once the countdown reaches the lead
  assign lead_eff = ctrl_ff.lead;
  assign lead_win = (intv_ff != 16'h0000) && (cnt_ff <= {9'h000, lead_eff});

  ////////////////////////////////////////////////////////////////////////////
  // Indicator state, gated by enable and suppression
  always_comb
  begin
    nxt_ind = 1'b0;
    if (ctrl_ff.en && !suppressed)
    begin
      nxt_ind = radio_active | lead_win;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ind_ff <= 1'b0;
      win_ff <= 1'b0;
    end
    else
    begin
      ind_ff <= nxt_ind;
      win_ff <= nxt_ind;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive with selectable polarity
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_ff <= RST_POL;
    end
    else
    begin
      pin_ff <= nxt_ind ^ ctrl_ff.pol;
    end
  end

  assign act_ind = pin_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Count indicator assertions, one per asserted period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      evcnt_ff <= 32'h0000_0000;
    end
    else if (wr_do && address == OFS_EVCNT)
    begin
      evcnt_ff <= 32'h0000_0000; // Any write clears
    end
    else if (nxt_ind && !win_ff)
    begin
      evcnt_ff <= evcnt_ff + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status view
  assign stat.ind = ind_ff;
  assign stat.sup = suppressed;
  assign stat.radio = radio_active;
  assign stat.cnt = cnt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux, unmapped offsets read zero
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (address)
      OFS_CTRL:
      begin
        nxt_rdata[CTRL_EN_BIT] = ctrl_ff.en;
        nxt_rdata[CTRL_POL_BIT] = ctrl_ff.pol;
        nxt_rdata[CTRL_LEAD_LSB +: CTRL_LEAD_W] = ctrl_ff.lead;
      end
      OFS_INTV:
      begin
        nxt_rdata[15:0] = intv_ff;
      end
      OFS_STAT:
      begin
        nxt_rdata[STAT_IND_BIT] = stat.ind;
        nxt_rdata[STAT_SUP_BIT] = stat.sup;
        nxt_rdata[STAT_RADIO_BIT] = stat.radio;
        nxt_rdata[STAT_CNT_LSB +: 16] = stat.cnt;
      end
      OFS_EVCNT:
      begin
        nxt_rdata = evcnt_ff;
      end
      default:
      begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in the wait cycle, stands while answered
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      readdata_ff <= 32'h0000_0000;
    end
    else if (read && !ack_ff)
    begin
      readdata_ff <= nxt_rdata;
    end
  end

  assign readdata = readdata_ff;

endmodule // ria_top
`default_nettype wire

// *** inc/ria_pkg.sv ***
// How it works
// - Indicator asserted whenever radio is active, if enabled and not suppressed
// - Polarity 0 active high, 1 active low
// - Lead time 0 to 20 ms, 312.5 us steps
// - One step jitter, early drift allowed
// - Intervals under 30 ms suppress the indicator
// - Interval back to 30 ms resumes indicator
// - Assert on every event despite slave latency
// - Enable, lead, polarity; enable defaults off
// - Stored configuration applied at every reset
package ria_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint STEP_NS = 64'd312500;
  localparam longint LEAD_MAX_NS = 64'd20000000;
  localparam longint INTV_MIN_NS = 64'd30000000;
  localparam longint LF_HZ = 64'd32000;
  localparam int LEAD_MAX_STEPS = int'(LEAD_MAX_NS / STEP_NS);
  localparam int INTV_MIN_STEPS = int'(INTV_MIN_NS / STEP_NS);
  localparam int LF_PER_STEP = int'((STEP_NS * LF_HZ) / 64'd1000000000);

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_INTV = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_EVCNT = 4'hC;

  // Control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_LEAD_LSB = 8;
  localparam int CTRL_LEAD_W = 7;

  // Status field positions
  localparam int STAT_IND_BIT = 0;
  localparam int STAT_SUP_BIT = 1;
  localparam int STAT_RADIO_BIT = 2;
  localparam int STAT_CNT_LSB = 16;

  // Stored configuration loaded at reset
  localparam logic RST_EN = 1'b0;
  localparam logic RST_POL = 1'b0;
  localparam logic [6:0] RST_LEAD = 7'h00;
  localparam logic [15:0] RST_INTV = 16'h0000;

  typedef struct packed {
    logic en;
    logic pol;
    logic [6:0] lead;
  } ria_ctrl_t;

  typedef struct packed {
    logic ind;
    logic sup;
    logic radio;
    logic [15:0] cnt;
  } ria_stat_t;

endpackage

// *** hdl/ria_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ria_sync
  import ria_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout,
  output logic rise
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops, then edge detect on the second only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign dout = sync_ff;
  assign rise = sync_ff & ~prev_ff;

endmodule // ria_sync
`default_nettype wire

// *** hdl/ria_step_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module ria_step_gen
  import ria_pkg::*;
#(
  parameter int DIV = LF_PER_STEP
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lf_rise,
  output logic step
);

  logic [7:0] div_ff;
  logic step_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Divide slow clock edges into lead-time steps
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      div_ff <= 8'h00;
      step_ff <= 1'b0;
    end
    else
    begin
      step_ff <= 1'b0;
      if (lf_rise)
      begin
        if (div_ff == 8'(DIV - 1))
        begin
          div_ff <= 8'h00;
          step_ff <= 1'b1;
        end
        else
        begin
          div_ff <= div_ff + 8'h01;
        end
      end
    end
  end

  assign step = step_ff;

endmodule // ria_step_gen
`default_nettype wire

// *** bench/ria_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module ria_top_sva
  import ria_pkg::*;
#(
  parameter int INTV_MIN = INTV_MIN_STEPS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic radio_active,
  input wire logic act_ind
);
  logic en_ff;
  logic pol_ff;
  logic [15:0] intv_ff;
  logic wr_ok;
  logic sup;
  assign wr_ok = write && !waitrequest && byteenable[0];
  assign sup = intv_ff < 16'(INTV_MIN);
  // Shadow of the setup written over the bus
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      en_ff <= RST_EN;
      pol_ff <= RST_POL;
      intv_ff <= RST_INTV;
    end
    else if (wr_ok && address == OFS_CTRL)
    begin
      en_ff <= writedata[CTRL_EN_BIT];
      pol_ff <= writedata[CTRL_POL_BIT];
    end
    else if (wr_ok && address == OFS_INTV)
      intv_ff <= writedata[15:0];
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> !act_ind)
    else $error("indicator not idle after reset");
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait state not one cycle");
  a_wait_idle: assert property (!read && !write |-> !waitrequest)
    else $error("waitrequest without request");
  a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0
    |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_radio_follow: assert property (radio_active && en_ff && !sup |=>
    act_ind != $past(pol_ff))
    else $error("indicator not asserted with radio");
  a_disabled_off: assert property (!en_ff |=> act_ind == $past(pol_ff))
    else $error("disabled indicator asserted");
  a_short_intv: assert property (en_ff && sup |=> act_ind == $past(pol_ff))
    else $error("indicator not suppressed");
  a_resume_on: assert property ($rose(!sup) && en_ff && radio_active |=>
    act_ind != $past(pol_ff))
    else $error("indicator did not resume");
endmodule // ria_top_sva
bind ria_top ria_top_sva #(.INTV_MIN(INTV_MIN)) u_sva
(
  .clk(clk),
  .sys_rst(sys_rst),
  .address(address),
  .read(read),
  .write(write),
  .byteenable(byteenable),
  .writedata(writedata),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .radio_active(radio_active),
  .act_ind(act_ind)
);
`default_nettype wire

// *** bench/ria_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ria_ctrl_model
  import ria_pkg::*;
#(
  parameter int SAMPLE_CYC = 20
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pol,
  input wire logic act_ind,
  output logic sampling,
  output var int warn_cnt
);
  logic seen_ff;
  int left_ff;
  assign sampling = left_ff != 0;
  // Sample sensors on each warning, done before the radio starts
  always_ff @(posedge clk)
  begin
    seen_ff <= !sys_rst && (act_ind ^ pol);
    if (sys_rst)
    begin
      left_ff <= 0;
      warn_cnt <= 0;
    end
    else if (!seen_ff && (act_ind ^ pol))
    begin
      left_ff <= SAMPLE_CYC;
      warn_cnt <= warn_cnt + 1;
    end
    else if (left_ff != 0)
      left_ff <= left_ff - 1;
  end
endmodule // ria_ctrl_model
`default_nettype wire

// *** bench/test_radio_activity_indicator.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) \
    begin \
      bad_count++; \
      $display("mismatch at %0t: %h vs %h", $time, a, b); \
    end \
  end
module test_radio_activity_indicator
  import ria_pkg::*;
;
  localparam int S = 16; // Clocks per step
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic lf_clk_pin = 1'b0;
  logic radio_active = 1'b0;
  logic evt_anchor = 1'b0;
  logic act_ind;
  logic sampling;
  int warn_cnt;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] rd;
  ria_top #(.LF_DIV(2)) dut
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .lf_clk_pin(lf_clk_pin),
    .radio_active(radio_active),
    .evt_anchor(evt_anchor),
    .act_ind(act_ind)
  );
  ria_ctrl_model u_ctrl (.clk(clk), .sys_rst(sys_rst), .pol(1'b0), .act_ind(act_ind),
    .sampling(sampling), .warn_cnt(warn_cnt));
  ////////////////////////////////////////
  // Clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  // Slow timebase and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3)
      lf_clk_pin <= ~lf_clk_pin;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One bus access, held until waitrequest is seen low
  // Only the cycle ceiling ends a wait that never gets an answer
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do
    begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
    `CHK(waitrequest, 1'b0)
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_lvl(input logic v, inout int n);
    while (act_ind !== v && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_INTV, 32'h0);
    rchk(OFS_STAT, 32'h2);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rchk(4'h2, 32'h0);
    // Lane 1 only: lead changes, enable and polarity stay
    byteenable <= 4'h2;
    bus(1'b1, OFS_CTRL, 32'h0000_0503);
    byteenable <= 4'hF;
    rchk(OFS_CTRL, 32'h0000_0500);
    `CHK(act_ind, 1'b0)
  endtask
  task automatic t_pol();
    bus(1'b1, OFS_INTV, 32'h64);
    bus(1'b1, OFS_CTRL, 32'h1);
    radio_active <= 1'b1;
    settle();
    `CHK(act_ind, 1'b1)
    bus(1'b1, OFS_CTRL, 32'h3);
    settle();
    `CHK(act_ind, 1'b0)
    bus(1'b1, OFS_CTRL, 32'h2);
    settle();
    `CHK(act_ind, 1'b1)
    radio_active <= 1'b0;
  endtask
  task automatic t_lead();
    int n;
    int w0;
    bus(1'b1, OFS_CTRL, 32'h7F01);
    rchk(OFS_CTRL, 32'h4001);
    bus(1'b1, OFS_CTRL, 32'h0201);
    evt_anchor <= 1'b1;
    @(posedge clk);
    evt_anchor <= 1'b0;
    n = 0;
    wait_lvl(1'b0, n);
    w0 = warn_cnt;
    n = 0;
    wait_lvl(1'b1, n);
    `CHK(n >= 98 * S - S && n <= 98 * S + S + 8, 1'b1)
    // Clear the assertion count while the window is open
    bus(1'b1, OFS_EVCNT, 32'h0);
    repeat (2 * S - 3) @(posedge clk);
    `CHK(sampling, 1'b0)
    radio_active <= 1'b1;
    repeat (8) @(posedge clk);
    radio_active <= 1'b0;
    n = 2 * S + 8;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    `CHK(n >= 100 * S - S && n <= 100 * S + S, 1'b1)
    // Model counts on the edge it sees the level, so let it land
    @(posedge clk);
    `CHK(warn_cnt - w0, 2)
    rchk(OFS_EVCNT, 32'h1);
  endtask
  task automatic t_sup();
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_INTV, 32'h5F);
    radio_active <= 1'b1;
    settle();
    `CHK(act_ind, 1'b0)
    bus(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[STAT_SUP_BIT], 1'b1)
    bus(1'b1, OFS_INTV, 32'h60);
    settle();
    `CHK(act_ind, 1'b1)
    radio_active <= 1'b0;
  endtask
  task automatic t_rerun();
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK(act_ind, 1'b0)
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_INTV, 32'h0);
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_pol();
    t_lead();
    t_sup();
    t_rerun();
    test_done();
  end
endmodule // test_radio_activity_indicator
`default_nettype wire
